// >>> uf_uart_defines.svh
// Register map, field positions, reset values and fixed counts of the UART block.
// Assumes the including file adds no other macro of the same name.
`ifndef UF_UART_DEFINES_SVH
`define UF_UART_DEFINES_SVH
`define UF_ADDR_DATA      32'hFFFF0700
`define UF_ADDR_IEN_DIVH  32'hFFFF0704
`define UF_ADDR_IID       32'hFFFF0708
`define UF_ADDR_LCR       32'hFFFF070C
`define UF_ADDR_STATUS    32'hFFFF0714
`define UF_ADDR_FRAC      32'hFFFF072C
`define UF_RST_BYTE       8'h00
`define UF_RST_FRAC       16'h0000
`define UF_FRAC_EN_BIT    15
`define UF_FRAC_M_HI      12
`define UF_FRAC_M_LO      11
`define UF_FRAC_N_HI      10
`define UF_FRAC_ONE       14'h0800
`define UF_TICKS_BIT      6'h0F
`define UF_TICKS_HALF     4'h7
`define UF_STOP_ONE       6'h0F
`define UF_STOP_ONE_HALF  6'h17
`define UF_STOP_TWO       6'h1F
`define UF_IID_NONE       3'h1
`define UF_IID_LINE       3'h6
`define UF_IID_RX         3'h4
`define UF_IID_TX         3'h2
`define UF_TXQ_DEPTH      8
`endif

// >>> uf_uart_pkg.sv
// Types shared by the UART block: line control layout, state enums and the state record.
// Assumes uf_uart_defines.svh is compiled alongside.
package uf_uart_pkg;
    typedef struct packed {
        logic       divisor_access_select;
        logic       force_break;
        logic       sp;
        logic       eps;
        logic       parity_enable;
        logic       stop;
        logic [1:0] wls;
    } uf_lcr_s;
    typedef enum logic [2:0] {
        UF_TX_IDLE = 3'b000, UF_TX_START = 3'b001, UF_TX_DATA = 3'b010,
        UF_TX_PAR = 3'b011, UF_TX_STOP = 3'b100
    } uf_tx_e;
    typedef enum logic [2:0] {
        UF_RX_IDLE = 3'b000, UF_RX_START = 3'b001, UF_RX_DATA = 3'b010,
        UF_RX_PAR = 3'b011, UF_RX_STOP = 3'b100
    } uf_rx_e;
    typedef struct packed {
        logic        rxd_meta;
        logic        rxd_sync;
        uf_lcr_s     lcr;
        logic [7:0]  div_lo;
        logic [7:0]  div_hi;
        logic [2:0]  ien;
        logic [15:0] frac;
        logic [8:0]  pre_cnt;
        logic [15:0] dl_cnt;
        logic [13:0] acc;
        logic        tick;
        uf_tx_e      tx_st;
        logic [7:0]  tx_shift;
        logic        tx_par;
        logic [5:0]  tx_tick;
        logic [2:0]  tx_bit;
        logic        txd;
        uf_rx_e      rx_st;
        logic [7:0]  rx_shift;
        logic        rx_par;
        logic [3:0]  rx_tick;
        logic [2:0]  rx_bit;
        logic [7:0]  rx_data;
        logic        dr;
        logic        oe;
        logic        pe;
        logic        fe;
        logic [15:0] rdata;
        logic        rvalid;
        logic        irq;
        logic        tx_ready;
    } uf_state_s;
endpackage

// >>> uf_uart.sv
// UART with fractional baud generator, shared-address data/divisor registers and a
// transmit queue. Assumes a single-cycle register bus on ref_clk and an async rxd pin.
`timescale 1ns/1ps
`include "uf_uart_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module uf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } uf_fifo_s;
    uf_fifo_s st_ff;
    uf_fifo_s nxt_st;
    logic     push;
    logic     pop;

    assign in_ready  = (st_ff.cnt != DEPTH[AW:0]);
    assign out_valid = (st_ff.cnt != '0);
    assign out_data  = st_ff.mem[st_ff.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wr] = in_data;
            nxt_st.wr = (st_ff.wr == AW'(DEPTH - 1)) ? '0 : st_ff.wr + 1'b1;
        end
        if (pop) begin
            nxt_st.rd = (st_ff.rd == AW'(DEPTH - 1)) ? '0 : st_ff.rd + 1'b1;
        end
        nxt_st.cnt = st_ff.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    a_fifo_no_overfill: assert property (@(posedge ref_clk) disable iff (reset)
        st_ff.cnt <= DEPTH[AW:0]) else $error("fifo count above depth");
endmodule // uf_fifo

////////////////////////////////////////////////////////////////////////////////
module uf_uart (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic [31:0] bus_addr,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    input  wire logic [15:0] bus_wdata,
    output logic      [15:0] bus_rdata_ff,
    output logic             bus_rvalid_ff,
    input  wire logic [2:0]  clock_divide_exponent,
    input  wire logic        rxd,
    output logic             txd_ff,
    output logic             irq_ff,
    output logic             tx_ready_ff
);
    import uf_uart_pkg::*;

    uf_state_s   st_ff;
    uf_state_s   nxt_st;
    logic [15:0] divisor_latch_value;
    logic [13:0] frac_k;
    logic [14:0] acc_sum;
    logic [8:0]  pre_last;
    logic        q_in_valid;
    logic        q_in_ready;
    logic        q_out_valid;
    logic        q_out_ready;
    logic [7:0]  q_out_data;
    logic        rx_done;
    logic [2:0]  nbits_last;
    logic [5:0]  stop_last;
    logic [2:0]  iid;

    assign divisor_latch_value = {st_ff.div_hi, st_ff.div_lo};
    assign nbits_last = {1'b1, st_ff.lcr.wls};
    assign stop_last  = !st_ff.lcr.stop ? `UF_STOP_ONE :
                        (st_ff.lcr.wls == 2'b00) ? `UF_STOP_ONE_HALF : `UF_STOP_TWO;
    assign pre_last   = (9'h002 << clock_divide_exponent) - 9'h001;
    // M of zero would tick on every divisor count, so it is treated as one
    assign frac_k     = !st_ff.frac[`UF_FRAC_EN_BIT] ? `UF_FRAC_ONE :
                        {1'b0,
                         (st_ff.frac[`UF_FRAC_M_HI:`UF_FRAC_M_LO] == 2'b00) ? 2'b01 :
                         st_ff.frac[`UF_FRAC_M_HI:`UF_FRAC_M_LO],
                         st_ff.frac[`UF_FRAC_N_HI:0]};
    assign acc_sum    = {1'b0, st_ff.acc} + {1'b0, `UF_FRAC_ONE};
    assign q_in_valid = bus_wr && (bus_addr == `UF_ADDR_DATA) && !st_ff.lcr.divisor_access_select;
    assign q_out_ready = (st_ff.tx_st == UF_TX_IDLE);
    assign rx_done    = st_ff.tick && (st_ff.rx_st == UF_RX_STOP) &&
                        (st_ff.rx_tick == `UF_TICKS_BIT);

    always_comb begin
        if (st_ff.ien[2] && (st_ff.oe || st_ff.pe || st_ff.fe)) begin
            iid = `UF_IID_LINE;
        end else if (st_ff.ien[0] && st_ff.dr) begin
            iid = `UF_IID_RX;
        end else if (st_ff.ien[1] && !q_out_valid) begin
            iid = `UF_IID_TX;
        end else begin
            iid = `UF_IID_NONE;
        end
    end

    function automatic logic [7:0] uf_mask(input logic [7:0] d, input logic [1:0] wls);
        uf_mask = d & (8'hFF >> (2'b11 - wls));
    endfunction

    function automatic logic uf_parity(input logic [7:0] d, input uf_lcr_s l);
        if (l.sp) begin
            uf_parity = l.eps;
        end else begin
            uf_parity = l.eps ? ^uf_mask(d, l.wls) : ~^uf_mask(d, l.wls);
        end
    endfunction

    uf_fifo #(
        .WIDTH (8),
        .DEPTH (`UF_TXQ_DEPTH)
    ) u_txq (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .in_valid  (q_in_valid),
        .in_ready  (q_in_ready),
        .in_data   (bus_wdata[7:0]),
        .out_valid (q_out_valid),
        .out_ready (q_out_ready),
        .out_data  (q_out_data)
    );

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rxd_meta = rxd;
        nxt_st.rxd_sync = st_ff.rxd_meta;
        nxt_st.rvalid = bus_rd;
        nxt_st.rdata = '0;
        nxt_st.tick = 1'b0;
        nxt_st.tx_ready = q_in_ready;
        // Baud generator: prescaler, divisor latch, then fractional accumulator
        if (divisor_latch_value == 16'h0000) begin
            nxt_st.pre_cnt = '0;
            nxt_st.dl_cnt = '0;
            nxt_st.acc = '0;
        end else if (st_ff.pre_cnt >= pre_last) begin
            nxt_st.pre_cnt = '0;
            if (st_ff.dl_cnt >= divisor_latch_value - 16'h0001) begin
                nxt_st.dl_cnt = '0;
                if (acc_sum >= {1'b0, frac_k}) begin
                    nxt_st.acc = 14'(acc_sum - {1'b0, frac_k});
                    nxt_st.tick = 1'b1;
                end else begin
                    nxt_st.acc = acc_sum[13:0];
                end
            end else begin
                nxt_st.dl_cnt = st_ff.dl_cnt + 16'h0001;
            end
        end else begin
            nxt_st.pre_cnt = st_ff.pre_cnt + 9'h001;
        end
        // Register writes
        if (bus_wr) begin
            case (bus_addr)
                `UF_ADDR_DATA: begin
                    if (st_ff.lcr.divisor_access_select) begin
                        nxt_st.div_lo = bus_wdata[7:0];
                    end
                end
                `UF_ADDR_IEN_DIVH: begin
                    if (st_ff.lcr.divisor_access_select) begin
                        nxt_st.div_hi = bus_wdata[7:0];
                    end else begin
                        nxt_st.ien = bus_wdata[2:0];
                    end
                end
                `UF_ADDR_LCR:  nxt_st.lcr = bus_wdata[7:0];
                `UF_ADDR_FRAC: nxt_st.frac = bus_wdata;
                default: ;
            endcase
        end
        // Register reads; clears come first so a same-cycle event still sets
        if (bus_rd) begin
            case (bus_addr)
                `UF_ADDR_DATA: begin
                    if (st_ff.lcr.divisor_access_select) begin
                        nxt_st.rdata = {8'h00, st_ff.div_lo};
                    end else begin
                        nxt_st.rdata = {8'h00, st_ff.rx_data};
                        nxt_st.dr = 1'b0;
                    end
                end
                `UF_ADDR_IEN_DIVH: begin
                    nxt_st.rdata = st_ff.lcr.divisor_access_select ? {8'h00, st_ff.div_hi} : {13'h0000, st_ff.ien};
                end
                `UF_ADDR_IID:  nxt_st.rdata = {13'h0000, iid};
                `UF_ADDR_LCR:  nxt_st.rdata = {8'h00, st_ff.lcr};
                `UF_ADDR_STATUS: begin
                    nxt_st.rdata = {9'h000, q_out_ready && !q_out_valid, !q_out_valid,
                                    1'b0, st_ff.fe, st_ff.pe, st_ff.oe, st_ff.dr};
                    nxt_st.oe = 1'b0;
                    nxt_st.pe = 1'b0;
                    nxt_st.fe = 1'b0;
                end
                `UF_ADDR_FRAC: nxt_st.rdata = st_ff.frac;
                default:       nxt_st.rdata = '0;
            endcase
        end
        // Transmitter, sixteen ticks per bit
        case (st_ff.tx_st)
            UF_TX_IDLE: begin
                if (q_out_valid) begin
                    nxt_st.tx_st = UF_TX_START;
                    nxt_st.tx_shift = q_out_data;
                    nxt_st.tx_par = uf_parity(q_out_data, st_ff.lcr);
                    nxt_st.tx_tick = '0;
                    nxt_st.tx_bit = '0;
                end
            end
            UF_TX_START, UF_TX_DATA, UF_TX_PAR: begin
                if (st_ff.tick) begin
                    nxt_st.tx_tick = st_ff.tx_tick + 6'h01;
                    if (st_ff.tx_tick == `UF_TICKS_BIT) begin
                        nxt_st.tx_tick = '0;
                        if (st_ff.tx_st == UF_TX_START) begin
                            nxt_st.tx_st = UF_TX_DATA;
                        end else if (st_ff.tx_st == UF_TX_DATA && st_ff.tx_bit != nbits_last) begin
                            nxt_st.tx_bit = st_ff.tx_bit + 3'h1;
                        end else if (st_ff.tx_st == UF_TX_DATA && st_ff.lcr.parity_enable) begin
                            nxt_st.tx_st = UF_TX_PAR;
                        end else begin
                            nxt_st.tx_st = UF_TX_STOP;
                        end
                    end
                end
            end
            UF_TX_STOP: begin
                if (st_ff.tick) begin
                    nxt_st.tx_tick = st_ff.tx_tick + 6'h01;
                    if (st_ff.tx_tick >= stop_last) begin
                        nxt_st.tx_st = UF_TX_IDLE;
                        nxt_st.tx_tick = '0;
                    end
                end
            end
            default: nxt_st.tx_st = UF_TX_IDLE;
        endcase
        case (nxt_st.tx_st)
            UF_TX_START: nxt_st.txd = 1'b0;
            UF_TX_DATA:  nxt_st.txd = nxt_st.tx_shift[nxt_st.tx_bit];
            UF_TX_PAR:   nxt_st.txd = nxt_st.tx_par;
            default:     nxt_st.txd = 1'b1;
        endcase
        if (nxt_st.lcr.force_break) begin
            nxt_st.txd = 1'b0;
        end
        // Receiver, sixteen ticks per bit, sampled mid-bit
        case (st_ff.rx_st)
            UF_RX_IDLE: begin
                if (!st_ff.rxd_sync) begin
                    nxt_st.rx_st = UF_RX_START;
                    nxt_st.rx_tick = '0;
                    nxt_st.rx_bit = '0;
                    nxt_st.rx_shift = '0;
                end
            end
            UF_RX_START: begin
                if (st_ff.tick) begin
                    nxt_st.rx_tick = st_ff.rx_tick + 4'h1;
                    if (st_ff.rx_tick == `UF_TICKS_HALF) begin
                        nxt_st.rx_tick = '0;
                        // A glitch shorter than half a bit is not a start
                        nxt_st.rx_st = st_ff.rxd_sync ? UF_RX_IDLE : UF_RX_DATA;
                    end
                end
            end
            UF_RX_DATA, UF_RX_PAR: begin
                if (st_ff.tick) begin
                    nxt_st.rx_tick = st_ff.rx_tick + 4'h1;
                    if (st_ff.rx_tick == `UF_TICKS_BIT) begin
                        if (st_ff.rx_st == UF_RX_PAR) begin
                            nxt_st.rx_par = st_ff.rxd_sync;
                            nxt_st.rx_st = UF_RX_STOP;
                        end else begin
                            nxt_st.rx_shift[st_ff.rx_bit] = st_ff.rxd_sync;
                            nxt_st.rx_bit = st_ff.rx_bit + 3'h1;
                            if (st_ff.rx_bit == nbits_last) begin
                                nxt_st.rx_st = st_ff.lcr.parity_enable ? UF_RX_PAR : UF_RX_STOP;
                            end
                        end
                    end
                end
            end
            UF_RX_STOP: begin
                if (st_ff.tick) begin
                    nxt_st.rx_tick = st_ff.rx_tick + 4'h1;
                end
                if (rx_done) begin
                    nxt_st.rx_st = UF_RX_IDLE;
                    nxt_st.rx_data = st_ff.rx_shift;
                    nxt_st.oe = st_ff.dr || st_ff.oe;
                    nxt_st.dr = 1'b1;
                    nxt_st.fe = !st_ff.rxd_sync || nxt_st.fe;
                    if (st_ff.lcr.parity_enable && st_ff.rx_par != uf_parity(st_ff.rx_shift, st_ff.lcr)) begin
                        nxt_st.pe = 1'b1;
                    end
                end
            end
            default: nxt_st.rx_st = UF_RX_IDLE;
        endcase
        nxt_st.irq = (st_ff.ien[2] && (st_ff.oe || st_ff.pe || st_ff.fe)) ||
                     (st_ff.ien[0] && st_ff.dr) ||
                     (st_ff.ien[1] && !q_out_valid);
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_ff <= '0;
            st_ff.rxd_meta <= 1'b1;
            st_ff.rxd_sync <= 1'b1;
            st_ff.txd <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign bus_rdata_ff  = st_ff.rdata;
    assign bus_rvalid_ff = st_ff.rvalid;
    assign txd_ff        = st_ff.txd;
    assign irq_ff        = st_ff.irq;
    assign tx_ready_ff   = st_ff.tx_ready;

    ////////////////////////////////////////////////////////////////////////////
    a_break_line_low: assert property (@(posedge ref_clk) disable iff (reset)
        st_ff.lcr.force_break |-> !txd_ff) else $error("break not holding line low");
    a_idle_line_high: assert property (@(posedge ref_clk) disable iff (reset)
        (st_ff.tx_st == UF_TX_IDLE && !st_ff.lcr.force_break) |-> txd_ff)
        else $error("idle line not high");
    a_start_bit_low: assert property (@(posedge ref_clk) disable iff (reset)
        (st_ff.tx_st == UF_TX_START) |-> !txd_ff) else $error("start bit not low");
    a_tick_spacing: assert property (@(posedge ref_clk) disable iff (reset)
        st_ff.tick |=> !st_ff.tick) else $error("baud ticks too close");
    a_div_low_write: assert property (@(posedge ref_clk) disable iff (reset)
        (bus_wr && bus_addr == `UF_ADDR_DATA && st_ff.lcr.divisor_access_select) |=>
        (st_ff.div_lo == $past(bus_wdata[7:0]))) else $error("low divisor not written");
    a_div_high_write: assert property (@(posedge ref_clk) disable iff (reset)
        (bus_wr && bus_addr == `UF_ADDR_IEN_DIVH && st_ff.lcr.divisor_access_select) |=>
        (divisor_latch_value[15:8] == $past(bus_wdata[7:0])))
        else $error("high divisor not written");
    a_rx_read_clear: assert property (@(posedge ref_clk) disable iff (reset)
        (bus_rd && bus_addr == `UF_ADDR_DATA && !st_ff.lcr.divisor_access_select && !rx_done) |=>
        (!st_ff.dr && bus_rvalid_ff && bus_rdata_ff[7:0] == $past(st_ff.rx_data)))
        else $error("receive read wrong");
    a_overrun_flag: assert property (@(posedge ref_clk) disable iff (reset)
        (rx_done && st_ff.dr && !(bus_rd && bus_addr == `UF_ADDR_DATA)) |=> st_ff.oe)
        else $error("overrun not flagged");
    a_stop_length: assert property (@(posedge ref_clk) disable iff (reset)
        (st_ff.tx_st == UF_TX_STOP && st_ff.tick && st_ff.tx_tick < stop_last) |=>
        (st_ff.tx_st == UF_TX_STOP)) else $error("stop period cut short");
    a_irq_rx_source: assert property (@(posedge ref_clk) disable iff (reset)
        (st_ff.ien[0] && st_ff.dr) |=> irq_ff) else $error("rx interrupt missing");
endmodule // uf_uart

// >>> uf_peer.sv
// Serial peer model for the UART bench: 8-bit, no parity, one stop bit both ways.
// Assumes the bench sets bit_cyc to the current bit length in ref_clk cycles.
`timescale 1ns/1ps
module uf_peer (
    input  wire logic        ref_clk,
    input  wire logic        txd,
    input  wire logic [15:0] bit_cyc,
    output logic             rxd
);
    logic [7:0] rq[$];
    logic [7:0] sh;
    initial rxd = 1'b1;
    // A low pulse shorter than half a bit, such as a short break, is not a frame
    always begin
        @(negedge txd);
        repeat (bit_cyc / 2) @(posedge ref_clk);
        if (!txd) begin
            for (int i = 0; i < 8; i++) begin
                repeat (bit_cyc) @(posedge ref_clk);
                sh[i] = txd;
            end
            repeat (bit_cyc) @(posedge ref_clk);
            if (txd) rq.push_back(sh);
        end
        wait (txd);
    end
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge ref_clk);
            #2 rxd = f[i];
            repeat (bit_cyc - 1) @(posedge ref_clk);
        end
    endtask
endmodule // uf_peer

// >>> tb_uart_with_fractional_baud.sv
// Self-checking bench for uf_uart: registers, serial traffic, break and fractional baud.
// Assumes uf_peer as the far side and a 20 MHz ref_clk.
`timescale 1ns/1ps
`include "uf_uart_defines.svh"
module tb_uart_with_fractional_baud;
    import uf_uart_pkg::*;
    logic        ref_clk, reset, bus_wr, bus_rd, rxd, txd_ff, irq_ff, tx_ready_ff;
    logic        bus_rvalid_ff;
    logic [31:0] bus_addr;
    logic [15:0] bus_wdata, bus_rdata_ff, bit_cyc, rv, d;
    logic [2:0]  cde;
    logic [7:0]  b;
    logic [7:0]  exp_q[$];
    int          num_errors, n_tests, cyc;
    uf_uart dut (.ref_clk(ref_clk), .reset(reset), .bus_addr(bus_addr), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata_ff(bus_rdata_ff),
        .bus_rvalid_ff(bus_rvalid_ff), .clock_divide_exponent(cde), .rxd(rxd),
        .txd_ff(txd_ff), .irq_ff(irq_ff), .tx_ready_ff(tx_ready_ff));
    uf_peer u_peer (.ref_clk(ref_clk), .txd(txd_ff), .bit_cyc(bit_cyc), .rxd(rxd));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("Errors %0d, checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        #2 bus_addr = a;
        bus_wdata = v;
        bus_wr = 1'b1;
        @(posedge ref_clk);
        #2 bus_wr = 1'b0;
    endtask
    // Read data stands one cycle only, so it is taken right after the answering edge
    task automatic rd(input logic [31:0] a, output logic [15:0] v);
        @(posedge ref_clk);
        #2 bus_addr = a;
        bus_rd = 1'b1;
        @(posedge ref_clk);
        #2 bus_rd = 1'b0;
        chk(16'h0001, {15'h0000, bus_rvalid_ff});
        v = bus_rdata_ff;
    endtask
    task automatic drain();
        int t;
        while (exp_q.size() > 0) begin
            t = 0;
            while (u_peer.rq.size() == 0 && t < 4000) begin
                @(posedge ref_clk);
                t++;
            end
            chk({8'h00, exp_q.pop_front()}, {8'h00, u_peer.rq.pop_front()});
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {bus_addr, bus_wdata, bus_wr, bus_rd, cde, cyc, num_errors, n_tests} = '0;
        bit_cyc = 16'h0020;
        reset = 1'b1;
        void'($urandom(32'h9D08));
        repeat (20) @(posedge ref_clk);
        #2 reset = 1'b0;
        rd(`UF_ADDR_DATA, rv);
        chk({8'h00, `UF_RST_BYTE}, rv);
        wr(`UF_ADDR_LCR, 16'h0083);
        rd(`UF_ADDR_DATA, rv);
        chk({8'h00, `UF_RST_BYTE}, rv);
        rd(`UF_ADDR_IEN_DIVH, rv);
        chk({8'h00, `UF_RST_BYTE}, rv);
        d = 16'($urandom);
        wr(`UF_ADDR_DATA, {8'h00, d[7:0]});
        wr(`UF_ADDR_IEN_DIVH, {8'h00, d[15:8]});
        rd(`UF_ADDR_DATA, rv);
        chk({8'h00, d[7:0]}, rv);
        rd(`UF_ADDR_IEN_DIVH, rv);
        chk({8'h00, d[15:8]}, rv);
        rd(32'hFFFF07F0, rv);
        chk(16'h0000, rv);
        // Divisor of one, exponent zero: 16 ticks of 2 cycles give 32 cycles a bit
        wr(`UF_ADDR_DATA, 16'h0001);
        wr(`UF_ADDR_IEN_DIVH, 16'h0000);
        wr(`UF_ADDR_LCR, 16'h0003);
        for (int i = 0; i < 4; i++) begin
            b = 8'($urandom);
            exp_q.push_back(b);
            wr(`UF_ADDR_DATA, {8'h00, b});
        end
        drain();
        b = 8'($urandom);
        exp_q.push_back(~b);
        wr(`UF_ADDR_DATA, {8'h00, ~b});
        u_peer.send(b);
        drain();
        repeat (40) @(posedge ref_clk);
        rd(`UF_ADDR_STATUS, rv);
        chk(16'h0061, rv);
        wr(`UF_ADDR_IEN_DIVH, 16'h0001);
        repeat (2) @(posedge ref_clk);
        #2 chk(16'h0001, {15'h0000, irq_ff});
        chk(16'h0001, {15'h0000, tx_ready_ff});
        rd(`UF_ADDR_DATA, rv);
        chk({8'h00, b}, rv);
        repeat (2) @(posedge ref_clk);
        #2 chk(16'h0000, {15'h0000, irq_ff});
        wr(`UF_ADDR_IEN_DIVH, 16'h0000);
        wr(`UF_ADDR_LCR, 16'h0043);
        repeat (3) @(posedge ref_clk);
        chk(16'h0000, {15'h0000, txd_ff});
        wr(`UF_ADDR_LCR, 16'h0003);
        repeat (3) @(posedge ref_clk);
        chk(16'h0001, {15'h0000, txd_ff});
        // Exponent one with M=2, N=1024: 16 * 4 * 2.5 gives 160 cycles a bit
        cde = 3'h1;
        bit_cyc = 16'h00A0;
        wr(`UF_ADDR_FRAC, 16'h9400);
        rd(`UF_ADDR_FRAC, rv);
        chk(16'h9400, rv);
        b = 8'($urandom);
        exp_q.push_back(b);
        wr(`UF_ADDR_DATA, {8'h00, b});
        drain();
        u_peer.send(~b);
        rd(`UF_ADDR_DATA, rv);
        chk({8'h00, ~b}, rv);
        conclude();
    end
endmodule // tb_uart_with_fractional_baud
